/* ecp_parallel_port_registers.sv */
// ecp_parallel_port_registers.sv: register decode and pin control of
// the host-side extended-capabilities parallel port.
// assumes an isa-style strobed i/o bus on clk_sys_i; pins from the cable
// are asynchronous and pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none

module ecp_parallel_port_registers (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // i/o bus
    input  wire logic [15:0] io_addr_i,
    input  wire logic        addr_enable_i,
    input  wire logic        io_read_i,
    input  wire logic        io_write_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_rvalid_o,
    // configuration
    input  wire logic [15:0] base_addr_i,
    input  wire logic        enhanced_enable_i,
    // printer pins
    input  wire logic [7:0]  port_data_lines_i,
    output logic      [7:0]  port_data_lines_o,
    output logic             port_data_lines_oe_n_o,
    output logic             host_strobe_n_o,
    output logic             autofeed_n_o,
    output logic             initiate_n_o,
    output logic             printer_select_out_n_o,
    input  wire logic        fault_n_i,
    input  wire logic        online_i,
    input  wire logic        paper_error_i,
    input  wire logic        periph_valid_n_i,
    input  wire logic        busy_i,
    // queue toward the ecp engine
    output logic      [8:0]  fifo_wdata_o,
    output logic             fifo_write_o,
    // interrupt requests
    output logic             ack_irq_o,
    output logic             error_irq_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [7:0] data_sync1;
        logic [7:0] data_sync2;
        logic       valid_last;
        logic       fault_last;
        logic [7:0] port_data;
        logic [5:0] device_control;
        logic [7:0] extended_control;
        logic [7:0] rdata;
        logic       rvalid;
        logic       rd_last;
        logic       wr_last;
        logic [7:0] pins_out;
        logic       pins_oe_n;
        logic       strobe_n;
        logic       autofeed_n;
        logic       initiate_n;
        logic       select_n;
        logic [8:0] fifo_wdata;
        logic       fifo_write;
        logic       ack_irq;
        logic       error_irq;
    } state_t;

    state_t st;
    state_t next_st;

    logic [10:0] offset;
    logic        hit;
    logic [2:0]  mode;
    logic        rd_pulse;
    logic        wr_pulse;
    logic        reverse;
    logic [7:0]  status_val;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        next_st = st;
        // pins are asynchronous: two flops before any use
        next_st.sync1 = {busy_i, periph_valid_n_i, paper_error_i,
                         online_i, fault_n_i};
        next_st.sync2 = st.sync1;
        next_st.data_sync1 = port_data_lines_i;
        next_st.data_sync2 = st.data_sync1;
        next_st.valid_last = st.sync2[3];
        next_st.fault_last = st.sync2[0];
        next_st.rd_last = io_read_i;
        next_st.wr_last = io_write_i;
        next_st.rvalid = 1'b0;
        next_st.fifo_write = 1'b0;

        mode = st.extended_control[7:5];
        offset = 11'(io_addr_i - base_addr_i);
        // offset window check; address enable blocks all decode
        hit = !addr_enable_i && (io_addr_i >= base_addr_i) &&
              ((io_addr_i - base_addr_i) < 16'h0403);
        rd_pulse = hit && io_read_i && !st.rd_last;
        wr_pulse = hit && io_write_i && !st.wr_last;

        status_val = {~st.sync2[4],
                      st.sync2[3], st.sync2[2], st.sync2[1],
                      st.sync2[0],
                      3'h0};

        // ****************************************************************
        // register writes
        // ****************************************************************
        if (wr_pulse) begin
            if (offset == ecp_port_pkg::OFF_DATA) begin
                if (mode == ecp_port_pkg::MODE_ECP) begin
                    // only meaningful going forward
                    if (!st.device_control[ecp_port_pkg::CTL_DIR]) begin
                        next_st.fifo_wdata = {1'b1, io_wdata_i};
                        next_st.fifo_write = 1'b1;
                    end
                end else begin
                    next_st.port_data = io_wdata_i;
                end
            end else if (offset == ecp_port_pkg::OFF_CONTROL) begin
                next_st.device_control = io_wdata_i[5:0];
            end else if (offset == ecp_port_pkg::OFF_FIFO) begin
                if (mode == ecp_port_pkg::MODE_FIFO ||
                    mode == ecp_port_pkg::MODE_ECP) begin
                    next_st.fifo_wdata = {1'b0, io_wdata_i};
                    next_st.fifo_write = 1'b1;
                end
            end else if (offset == ecp_port_pkg::OFF_EXT_CTRL) begin
                // enhanced mode held off unless configuration allows it
                if (io_wdata_i[7:5] == ecp_port_pkg::MODE_ENHANCED &&
                    !enhanced_enable_i) begin
                    next_st.extended_control = {mode, io_wdata_i[4:0]};
                end else begin
                    next_st.extended_control = io_wdata_i;
                end
            end
        end

        // ****************************************************************
        // register reads
        // ****************************************************************
        if (rd_pulse) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = 8'h00;
            if (offset == ecp_port_pkg::OFF_DATA) begin
                if (mode == ecp_port_pkg::MODE_BIDIR ||
                    mode == ecp_port_pkg::MODE_STANDARD) begin
                    next_st.rdata = st.data_sync2;
                end
            end else if (offset == ecp_port_pkg::OFF_STATUS) begin
                next_st.rdata = status_val;
            end else if (offset == ecp_port_pkg::OFF_CONTROL) begin
                next_st.rdata = {2'b00, st.device_control};
            end else if (offset == ecp_port_pkg::OFF_FIFO) begin
                if (mode == ecp_port_pkg::MODE_CONFIG) begin
                    next_st.rdata = ecp_port_pkg::CONFIG_A_VAL;
                end
            end else if (offset == ecp_port_pkg::OFF_CONFIG_B) begin
                if (mode == ecp_port_pkg::MODE_CONFIG) begin
                    next_st.rdata = ecp_port_pkg::CONFIG_B_VAL;
                end
            end else if (offset == ecp_port_pkg::OFF_EXT_CTRL) begin
                next_st.rdata = st.extended_control;
            end
        end

        // ****************************************************************
        // pin drive
        // ****************************************************************
        // direction bit has no effect in modes 000 and 010
        reverse = st.device_control[ecp_port_pkg::CTL_DIR] &&
                  mode != ecp_port_pkg::MODE_STANDARD &&
                  mode != ecp_port_pkg::MODE_FIFO;
        next_st.pins_out = st.port_data;
        // in ecp forward, release data once reversal is granted (reverse releases at once);
        // paper_error doubles as the grant line
        if (reverse) begin
            next_st.pins_oe_n = 1'b1;
        end else if (mode == ecp_port_pkg::MODE_ECP) begin
            next_st.pins_oe_n = !st.sync2[2];
        end else begin
            next_st.pins_oe_n = 1'b0;
        end
        next_st.strobe_n = ~st.device_control[ecp_port_pkg::CTL_STROBE];
        // autofeed doubles as the host handshake in ecp mode
        next_st.autofeed_n =
            ~st.device_control[ecp_port_pkg::CTL_AUTOFEED];
        next_st.initiate_n =
            st.device_control[ecp_port_pkg::CTL_INIT];
        if (mode == ecp_port_pkg::MODE_ECP) begin
            next_st.select_n = 1'b1;
        end else begin
            next_st.select_n =
                ~st.device_control[ecp_port_pkg::CTL_SELECT];
        end

        // ****************************************************************
        // interrupt requests
        // ****************************************************************
        next_st.ack_irq = st.device_control[ecp_port_pkg::CTL_ACK_IRQ] &&
                          st.sync2[3] && !st.valid_last;
        // fault falling edge, forward direction only
        next_st.error_irq = !st.extended_control[ecp_port_pkg::ECR_ERR_DIS]
                            && !reverse
                            && !st.sync2[0] && st.fault_last;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
            st.sync1 <= 5'h1f;
            st.sync2 <= 5'h1f;
            st.valid_last <= 1'b1;
            st.fault_last <= 1'b1;
            st.port_data <= ecp_port_pkg::RST_DATA;
            st.device_control <= ecp_port_pkg::RST_CONTROL;
            st.extended_control <= ecp_port_pkg::RST_EXT_CTRL;
            st.strobe_n <= 1'b1;
            st.autofeed_n <= 1'b1;
            st.select_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign io_rdata_o             = st.rdata;
    assign io_rvalid_o            = st.rvalid;
    assign port_data_lines_o      = st.pins_out;
    assign port_data_lines_oe_n_o = st.pins_oe_n;
    assign host_strobe_n_o        = st.strobe_n;
    assign autofeed_n_o           = st.autofeed_n;
    assign initiate_n_o           = st.initiate_n;
    assign printer_select_out_n_o = st.select_n;
    assign fifo_wdata_o           = st.fifo_wdata;
    assign fifo_write_o           = st.fifo_write;
    assign ack_irq_o              = st.ack_irq;
    assign error_irq_o            = st.error_irq;

endmodule : ecp_parallel_port_registers

`default_nettype wire

/* ecp_port_pkg.sv */
// ecp_port_pkg.sv: offsets, field positions, modes and reset values
// for the extended-capabilities parallel port register block.
// assumes an 8-bit isa-style i/o bus with an 11-bit port offset.
package ecp_port_pkg;

    // ****************************************************************
    // register offsets from the configured base
    // ****************************************************************
    localparam logic [10:0] OFF_DATA      = 11'h000;
    localparam logic [10:0] OFF_STATUS    = 11'h001;
    localparam logic [10:0] OFF_CONTROL   = 11'h002;
    localparam logic [10:0] OFF_FIFO      = 11'h400;
    localparam logic [10:0] OFF_CONFIG_B  = 11'h401;
    localparam logic [10:0] OFF_EXT_CTRL  = 11'h402;

    // ****************************************************************
    // mode field encodings
    // ****************************************************************
    localparam logic [2:0] MODE_STANDARD = 3'h0;
    localparam logic [2:0] MODE_BIDIR    = 3'h1;
    localparam logic [2:0] MODE_FIFO     = 3'h2;
    localparam logic [2:0] MODE_ECP      = 3'h3;
    localparam logic [2:0] MODE_ENHANCED = 3'h4;
    localparam logic [2:0] MODE_RESERVED = 3'h5;
    localparam logic [2:0] MODE_TEST     = 3'h6;
    localparam logic [2:0] MODE_CONFIG   = 3'h7;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTL_STROBE   = 0;
    localparam int CTL_AUTOFEED = 1;
    localparam int CTL_INIT     = 2;
    localparam int CTL_SELECT   = 3;
    localparam int CTL_ACK_IRQ  = 4;
    localparam int CTL_DIR      = 5;
    localparam int STS_FAULT    = 3;
    localparam int STS_ONLINE   = 4;
    localparam int STS_PAPER    = 5;
    localparam int STS_VALID    = 6;
    localparam int STS_BUSY     = 7;
    localparam int ECR_MODE_LO  = 5;
    localparam int ECR_ERR_DIS  = 4;

    // ****************************************************************
    // reset values and constant read values
    // ****************************************************************
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [5:0] RST_CONTROL  = 6'h00;
    localparam logic [7:0] RST_EXT_CTRL = 8'h10;
    localparam logic [7:0] CONFIG_A_VAL = 8'h10;
    localparam logic [7:0] CONFIG_B_VAL = 8'h00;

endpackage : ecp_port_pkg

/* ecp_port_chk.sv */
// ecp_port_chk.sv: port-level assertions for the parallel port block.
// assumes it is bound to ecp_parallel_port_registers, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ecp_port_chk (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic [15:0] io_addr_i,
    input wire logic        addr_enable_i,
    input wire logic        io_read_i,
    input wire logic        io_write_i,
    input wire logic [7:0]  io_wdata_i,
    input wire logic [7:0]  io_rdata_o,
    input wire logic        io_rvalid_o,
    input wire logic [15:0] base_addr_i,
    input wire logic        enhanced_enable_i,
    input wire logic        port_data_lines_oe_n_o,
    input wire logic        host_strobe_n_o,
    input wire logic        printer_select_out_n_o,
    input wire logic [8:0]  fifo_wdata_o,
    input wire logic        fifo_write_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // ****************************************************************
    // shadow of what the bus has written, for mode-dependent checks
    // ****************************************************************
    logic [15:0] off;
    logic [10:0] rd_off;
    logic [2:0]  mode_q;
    logic        prev_rd, prev_wr, rd_take, wr_take, dir_q;
    assign off = io_addr_i - base_addr_i;
    assign rd_take = io_read_i && !prev_rd && !addr_enable_i
                     && off <= 16'h0402;
    assign wr_take = io_write_i && !prev_wr && !addr_enable_i
                     && off <= 16'h0402;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            {prev_rd, prev_wr, dir_q, mode_q, rd_off} <= '0;
        end else begin
            prev_rd <= io_read_i;
            prev_wr <= io_write_i;
            if (rd_take)
                rd_off <= off[10:0];
            // mode 100 only sticks when the enhanced option is on
            if (wr_take && off == 16'h0402 && (enhanced_enable_i
                || io_wdata_i[7:5] != ecp_port_pkg::MODE_ENHANCED))
                mode_q <= io_wdata_i[7:5];
            if (wr_take && off == 16'h0002)
                dir_q <= io_wdata_i[5];
        end
    end
    sequence ctrl_write;
        wr_take && off == 16'h0002 && mode_q <= 3'h1;
    endsequence
    a_read_answer: assert property (rd_take |-> ##[1:2] io_rvalid_o)
        else $error("read not answered");
    a_blocked_read: assert property (io_read_i && !prev_rd && addr_enable_i
        && !io_rvalid_o |=> !io_rvalid_o [*2]) else $error("read answered");
    a_ctrl_top_zero: assert property (io_rvalid_o && rd_off == 11'h002
        |-> io_rdata_o[7:6] == 2'h0) else $error("control top bits set");
    a_strobe_follow: assert property (ctrl_write |-> ##2
        host_strobe_n_o == !$past(io_wdata_i[0], 2))
        else $error("strobe not inverted bit 0");
    a_select_follow: assert property (ctrl_write |-> ##2
        printer_select_out_n_o == !$past(io_wdata_i[3], 2))
        else $error("select not inverted bit 3");
    a_select_ecp: assert property (mode_q == 3'h3 && $past(mode_q) == 3'h3
        |-> printer_select_out_n_o) else $error("select asserted in ecp");
    a_addr_tag: assert property (wr_take && off == 16'h0 && mode_q == 3'h3
        && !dir_q |-> ##[1:2] fifo_write_o && fifo_wdata_o[8])
        else $error("command byte not queued");
    a_oe_reverse: assert property (mode_q == 3'h1 && dir_q && $stable(dir_q)
        && $stable(mode_q) |-> port_data_lines_oe_n_o)
        else $error("data driven in reverse");
    a_oe_standard: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h0
        |-> !port_data_lines_oe_n_o) else $error("data released in mode 0");
endmodule : ecp_port_chk
bind ecp_parallel_port_registers ecp_port_chk u_chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
    .addr_enable_i(addr_enable_i), .io_read_i(io_read_i),
    .io_write_i(io_write_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .base_addr_i(base_addr_i), .enhanced_enable_i(enhanced_enable_i),
    .port_data_lines_oe_n_o(port_data_lines_oe_n_o),
    .host_strobe_n_o(host_strobe_n_o),
    .printer_select_out_n_o(printer_select_out_n_o),
    .fifo_wdata_o(fifo_wdata_o), .fifo_write_o(fifo_write_o));
`default_nettype wire

/* ecp_periph_model.sv */
// ecp_periph_model.sv: behavioural peripheral on the parallel cable.
// assumes the bench sets the status levels and the reverse-data byte.
`timescale 1ns/1ps
`default_nettype none
module ecp_periph_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] host_data_i,
    input  wire logic       host_oe_n_i,
    input  wire logic       autofeed_n_i,
    input  wire logic       initiate_n_i,
    input  wire logic       select_n_i,
    input  wire logic [4:0] level_i,
    input  wire logic [7:0] reply_i,
    output logic      [7:0] lines_o,
    output logic      [4:0] status_o
);
    logic [7:0] last = 8'h00;
    logic       talk;
    assign talk = !initiate_n_i && !autofeed_n_i && select_n_i;
    // released lines float: show a value that flips every cycle
    assign lines_o = !host_oe_n_i ? host_data_i : talk ? reply_i : ~last;
    always @(posedge clk_sys_i) last <= lines_o;
    // grant goes low while reverse is asked; fault is a free hint
    assign status_o = {level_i[4:3], initiate_n_i & level_i[2],
                       level_i[1:0]};
endmodule : ecp_periph_model
`default_nettype wire

/* ecp_parallel_port_registers_tb.sv */
// ecp_parallel_port_registers_tb.sv: self-checking bench for the port.
// assumes the peripheral model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module ecp_parallel_port_registers_tb;
    localparam logic [15:0] BASE = 16'h0200;
    logic        clk, rst, aen, rd_s, wr_s, enh, oe_n, stb_n, afd_n;
    logic        ini_n, sel_n, fwr, rv, airq, eirq;
    logic [15:0] addr;
    logic [7:0]  wd, rdat, pd_in, pd_out, q;
    logic [8:0]  fwd, last_f;
    logic [4:0]  level, st;
    logic [2:0]  pm;
    int          failures, n_checks, n_fifo, n_ack, n_err, i;
    ecp_parallel_port_registers dut (.clk_sys_i(clk), .reset_i(rst),
        .io_addr_i(addr), .addr_enable_i(aen), .io_read_i(rd_s),
        .io_write_i(wr_s), .io_wdata_i(wd), .io_rdata_o(rdat),
        .io_rvalid_o(rv), .base_addr_i(BASE), .enhanced_enable_i(enh),
        .port_data_lines_i(pd_in), .port_data_lines_o(pd_out),
        .port_data_lines_oe_n_o(oe_n), .host_strobe_n_o(stb_n),
        .autofeed_n_o(afd_n), .initiate_n_o(ini_n),
        .printer_select_out_n_o(sel_n), .fault_n_i(st[0]),
        .online_i(st[1]), .paper_error_i(st[2]), .periph_valid_n_i(st[3]),
        .busy_i(st[4]), .fifo_wdata_o(fwd), .fifo_write_o(fwr),
        .ack_irq_o(airq), .error_irq_o(eirq));
    ecp_periph_model u_periph (.clk_sys_i(clk), .host_data_i(pd_out),
        .host_oe_n_i(oe_n), .autofeed_n_i(afd_n), .initiate_n_i(ini_n),
        .select_n_i(sel_n), .level_i(level), .reply_i(8'ha5),
        .lines_o(pd_in), .status_o(st));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // pulses launch on the rising edge; look at them mid-cycle
    always @(negedge clk) begin
        if (fwr === 1'b1) begin
            n_fifo++;
            last_f = fwd;
        end
        if (airq === 1'b1) n_ack++;
        if (eirq === 1'b1) n_err++;
    end
    // ****************************************************************
    // bus access: strobe held three cycles, then two idle cycles
    // ****************************************************************
    task automatic acc(input logic w, input logic [10:0] o,
                       input logic [7:0] d);
        @(negedge clk);
        q = 8'hxx;
        addr = BASE + {5'h00, o};
        wd = d;
        if (w) wr_s = 1'b1; else rd_s = 1'b1;
        repeat (3) @(negedge clk) if (rv === 1'b1) q = rdat;
        {wr_s, rd_s} = 2'b00;
        repeat (2) @(negedge clk);
    endtask : acc
    task automatic wr(input logic [10:0] o, input logic [7:0] d);
        acc(1'b1, o, d);
    endtask : wr
    task automatic rd(input logic [10:0] o, input logic [7:0] e);
        acc(1'b0, o, 8'h00);
        `CHK(q, e)
    endtask : rd
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        #(40 * 20000);
        failures++;
        final_report;
    end
    initial begin
        {aen, rd_s, wr_s, enh, wd, addr, level} = '0;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({stb_n, afd_n, ini_n, sel_n, oe_n, pd_out}, 13'h1a00)
        rd(11'h002, 8'h00);
        $display("test reset done");
        wr(11'h002, 8'hff);
        rd(11'h002, 8'h3f);
        `CHK({stb_n, afd_n, ini_n, sel_n, oe_n}, 5'b00100)
        wr(11'h002, 8'h00);
        `CHK({stb_n, afd_n, ini_n, sel_n, oe_n}, 5'b11010)
        aen = 1'b1;
        wr(11'h002, 8'h0f);
        rd(11'h002, 8'hxx);
        aen = 1'b0;
        rd(11'h002, 8'h00);
        rd(11'h003, 8'h00);
        wr(11'h000, 8'h5a);
        `CHK(pd_out, 8'h5a)
        rd(11'h000, 8'h5a);
        $display("test control and data done");
        wr(11'h002, 8'h04);
        foreach (pm[k]) begin
            level = {k[0], 1'b1, k[1], 1'b0, ~k[0]} ^ 5'h15;
            repeat (8) @(negedge clk);
            rd(11'h001, {~level[4], level[3:0], 3'h0});
        end
        $display("test status done");
        for (i = 0; i < 8; i++) begin
            wr(11'h402, {i[2:0], 5'h10});
            if (i != 4) pm = i[2:0];
            acc(1'b0, 11'h402, 8'h00);
            `CHK(q[7:5], pm)
        end
        rd(11'h400, ecp_port_pkg::CONFIG_A_VAL);
        enh = 1'b1;
        wr(11'h402, 8'h90);
        acc(1'b0, 11'h402, 8'h00);
        `CHK(q[7:5], 3'h4)
        $display("test modes done");
        level = 5'h01;
        wr(11'h402, 8'h30);
        wr(11'h002, 8'h22);
        `CHK(oe_n, 1'b1)
        rd(11'h000, 8'ha5);
        $display("test reverse done");
        wr(11'h402, 8'h60);
        wr(11'h002, 8'h1c);
        `CHK(sel_n, 1'b1)
        {n_fifo, n_ack, n_err} = '0;
        wr(11'h000, 8'h3c);
        `CHK(last_f, 9'h13c)
        wr(11'h400, 8'h77);
        `CHK(last_f, 9'h077)
        wr(11'h002, 8'h3c);
        wr(11'h000, 8'h11);
        `CHK(n_fifo, 2)
        wr(11'h002, 8'h1c);
        level = 5'h08;
        repeat (8) @(negedge clk);
        `CHK(n_err, 1)
        `CHK(n_ack, 1)
        $display("test ecp done");
        final_report;
    end
endmodule : ecp_parallel_port_registers_tb
`default_nettype wire
